// ---- wss_jump_port.sv ----
// Capture stage of the parallel dynamic jump port.
// Assumes the selection pins are synchronous to clk_sys.
`timescale 1ns/1ps
module wss_jump_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Jump pins
  input wire logic jump_valid,
  input wire logic [wss_pkg::CH_W-1:0] jump_sel,
  input wire logic [wss_pkg::JIDX_W-1:0] jump_idx,
  // Captured selection
  output logic hit,
  output logic [wss_pkg::CH_W-1:0] hit_ch,
  output logic [wss_pkg::SEGNUM_W-1:0] hit_seg
);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hit <= 1'b0;
      hit_ch <= '0;
      hit_seg <= '0;
    end else begin
      hit <= jump_valid; // R17
      if (jump_valid) begin // R17
        hit_ch <= jump_sel; // R10
        hit_seg <= {7'h00, jump_idx} + 17'h00001; // R10
      end
    end
  end

  chk_jump_ignore: assert property (@(posedge clk_sys) disable iff (sys_rst) // R17
    !jump_valid |=> !hit && $stable(hit_ch) && $stable(hit_seg))
    else $error("jump port moved without valid");

  chk_jump_capture: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
    jump_valid |=> hit && hit_ch == $past(jump_sel)
      && hit_seg == {7'h00, $past(jump_idx)} + 17'h00001)
    else $error("jump selection not captured");

endmodule

// ---- wss_mem_model.sv ----
// Memory side model: accepts requests, drops to half rate on command.
// Assumes requests follow the valid and ready handshake.
`timescale 1ns/1ps
module wss_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic slow,
  // Request stream
  output logic req_ready
);
  logic ph_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
    end
  end
  // Consumes at full rate, or on every other cycle while slow is set
  assign req_ready = !slow || ph_reg;
endmodule

// ---- wss_pkg.sv ----
// Shared constants and types of the waveform segment sequencer.
// Assumes one sample clock for all channels and a 32-bit register port.
package wss_pkg;

  localparam int CH_W = 2;
  localparam int MAX_CH = 4;
  localparam int JIDX_W = 10;
  localparam int SEGNUM_W = 17;
  localparam int SEGIX_W = 16;
  localparam int SEG_DEPTH = 65536;
  localparam int TASK_W = 16;
  localparam int TASK_DEPTH = 65536;
  localparam int SCEN_W = 10;
  localparam int SCEN_DEPTH = 1024;
  localparam int SCNT_W = 11;
  localparam int LOOP_W = 15;
  localparam int ADDR_W = 32;
  localparam int REG_AW = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ARB_SEL = 8'h04;
  localparam logic [7:0] OFF_TASK_IDX = 8'h08;
  localparam logic [7:0] OFF_TASK_LO = 8'h0C;
  localparam logic [7:0] OFF_TASK_HI = 8'h10;
  localparam logic [7:0] OFF_SCEN_IDX = 8'h14;
  localparam logic [7:0] OFF_SCEN_DATA = 8'h18;
  localparam logic [7:0] OFF_SCEN_CNT = 8'h1C;
  localparam logic [7:0] OFF_SEG_IDX = 8'h20;
  localparam logic [7:0] OFF_SEG_START = 8'h24;
  localparam logic [7:0] OFF_SEG_LEN = 8'h28;
  localparam logic [7:0] OFF_SEG_MBASE = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TASK = 1;
  localparam int CTRL_STREAM = 2;
  localparam int SEL_CH_LSB = 20;
  localparam int LO_LOOP_LSB = 17;
  localparam int HI_END = 16;
  localparam int HI_COND_LSB = 17;
  localparam int HI_ADV_LSB = 19;
  localparam int STAT_DONE_LSB = 4;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [SCNT_W-1:0] SCEN_DFLT_CNT = 11'h001;
  localparam logic [TASK_W-1:0] SCEN_DFLT_PTR = 16'h0000;

  typedef struct packed {
    logic [SEGNUM_W-1:0] seg;
    logic [LOOP_W-1:0] loops;
    logic [TASK_W-1:0] next;
    logic last;
    logic [1:0] cond;
    logic [1:0] adv;
  } wss_task_t;

  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] maddr;
    logic last;
  } wss_req_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_TASK,
    S_PLAY,
    S_DONE
  } wss_state_t;

endpackage

// ---- wss_sequencer.sv ----
// Waveform segment sequencer: arbitrary and task playback per channel.
// Assumes waveform memory takes one request per cycle under ready.
//
// Functional notes
// R1: Arbitrary mode plays one selected segment
// R2: Task entry holds segment, loops, conditions, next
// R3: One task table per channel, 64K entries
// R4: Scenario table of 1K start-task pointers
// R5: Default scenario: one line, first task
// R6: Follow task chain to end, then next line
// R7: Markers synchronous, stored apart from samples
// R8: Marker length equals its segment length
// R9: Markers divided evenly among channels
// R10: Jump port: 2-bit channel, valid, 10-bit index
// R11: External controller times jump-driven playback
// R12: Streaming disables all marker outputs
// R13: Host streams faster than consumption
// R14: Samples read in strictly sequential order
// R15: All channels share one sample rate
// R16: Segment numbers run from 1 to 64K
// R17: Jump fields sampled only with valid
// R18: Jump changes only the named channel
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module wss_sequencer #(
  parameter int NUM_CH = 4,
  parameter int NUM_MARK = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [wss_pkg::REG_AW-1:0] reg_addr,
  input wire logic [wss_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wss_pkg::DATA_W-1:0] reg_rdata,
  // Dynamic jump pins
  input wire logic jump_valid,
  input wire logic [wss_pkg::CH_W-1:0] jump_sel,
  input wire logic [wss_pkg::JIDX_W-1:0] jump_idx,
  // Memory request stream
  output logic req_valid,
  input wire logic req_ready,
  output wss_pkg::wss_req_t req_data,
  // Status pins
  output logic stream_active,
  output logic [NUM_MARK-1:0] marker_en
);

  localparam int MPC = NUM_MARK / NUM_CH;

  wss_pkg::wss_task_t task_mem [NUM_CH*wss_pkg::TASK_DEPTH];
  logic [wss_pkg::TASK_W-1:0] scen_mem [NUM_CH*wss_pkg::SCEN_DEPTH];
  logic [wss_pkg::ADDR_W-1:0] seg_start_mem [wss_pkg::SEG_DEPTH];
  logic [wss_pkg::ADDR_W-1:0] seg_len_mem [wss_pkg::SEG_DEPTH];
  logic [wss_pkg::ADDR_W-1:0] seg_mb_mem [wss_pkg::SEG_DEPTH];

  logic [2:0] ctrl_reg;
  logic [wss_pkg::DATA_W-1:0] task_idx_reg;
  logic [wss_pkg::DATA_W-1:0] task_lo_reg;
  logic [wss_pkg::DATA_W-1:0] scen_idx_reg;
  logic [wss_pkg::SEGIX_W-1:0] seg_idx_reg;
  logic [wss_pkg::ADDR_W-1:0] seg_start_reg;
  logic [wss_pkg::ADDR_W-1:0] seg_len_reg;
  logic [wss_pkg::SCNT_W-1:0] scen_cnt_reg [NUM_CH];
  logic [NUM_CH-1:0] dflt_reg;

  wss_pkg::wss_state_t st_reg [NUM_CH];
  logic [wss_pkg::SEGNUM_W-1:0] cur_seg_reg [NUM_CH];
  logic [wss_pkg::SEGNUM_W-1:0] arb_seg_reg [NUM_CH];
  logic [wss_pkg::ADDR_W-1:0] off_reg [NUM_CH];
  logic [wss_pkg::LOOP_W-1:0] loops_reg [NUM_CH];
  logic [wss_pkg::TASK_W-1:0] tptr_reg [NUM_CH];
  logic [wss_pkg::TASK_W-1:0] tnext_reg [NUM_CH];
  logic [NUM_CH-1:0] tend_reg;
  logic [wss_pkg::SCEN_W-1:0] line_reg [NUM_CH];
  logic [wss_pkg::CH_W-1:0] rr_reg;

  logic wr_ctrl;
  logic wr_arb;
  logic start_p;
  logic run;
  logic task_mode;
  logic stream;
  logic [wss_pkg::CH_W-1:0] arb_ch;
  logic hit;
  logic [wss_pkg::CH_W-1:0] hit_ch;
  logic [wss_pkg::SEGNUM_W-1:0] hit_seg;
  logic [NUM_CH-1:0] sel_p;
  logic [wss_pkg::SEGNUM_W-1:0] sel_seg [NUM_CH];
  wss_pkg::wss_task_t task_rd [NUM_CH];
  logic [wss_pkg::ADDR_W-1:0] start_c [NUM_CH];
  logic [wss_pkg::ADDR_W-1:0] len_c [NUM_CH];
  logic [wss_pkg::ADDR_W-1:0] mb_c [NUM_CH];
  logic [NUM_CH-1:0] last_c;
  logic issue;
  logic buf_ready;
  wss_pkg::wss_req_t in_d;

  // Segment number to table index; number n lives at n-1
  function automatic logic [wss_pkg::SEGIX_W-1:0] seg_ix(input logic [16:0] n);
    logic [16:0] t;
    t = n - 17'h00001;
    return t[15:0];
  endfunction

  // Per-channel table index
  function automatic logic [17:0] tix(input int c, input logic [15:0] i);
    logic [1:0] cc;
    cc = 2'(c);
    return {cc, i};
  endfunction

  function automatic logic [11:0] six(input int c, input logic [9:0] i);
    logic [1:0] cc;
    cc = 2'(c);
    return {cc, i};
  endfunction

  function automatic logic [15:0] scen_ptr(input int c, input logic [9:0] line);
    logic [15:0] p;
    p = dflt_reg[c] ? wss_pkg::SCEN_DFLT_PTR : scen_mem[six(c, line)];
    return p;
  endfunction

  function automatic logic [10:0] scen_count(input int c);
    logic [10:0] n;
    n = dflt_reg[c] ? wss_pkg::SCEN_DFLT_CNT : scen_cnt_reg[c];
    return n;
  endfunction

  assign wr_ctrl = reg_wr && reg_addr == wss_pkg::OFF_CTRL;
  assign wr_arb = reg_wr && reg_addr == wss_pkg::OFF_ARB_SEL;
  assign start_p = wr_ctrl && reg_wdata[wss_pkg::CTRL_RUN];
  assign run = ctrl_reg[wss_pkg::CTRL_RUN];
  assign task_mode = wr_ctrl ? reg_wdata[wss_pkg::CTRL_TASK] : ctrl_reg[wss_pkg::CTRL_TASK];
  assign stream = ctrl_reg[wss_pkg::CTRL_STREAM];
  assign arb_ch = reg_wdata[wss_pkg::SEL_CH_LSB +: wss_pkg::CH_W];

  wss_jump_port u_jump (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .jump_valid(jump_valid),
    .jump_sel(jump_sel),
    .jump_idx(jump_idx),
    .hit(hit),
    .hit_ch(hit_ch),
    .hit_seg(hit_seg)
  );

  // Selection pulses per channel; a software write wins over a jump
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      sel_p[c] = 1'b0;
      sel_seg[c] = '0;
      if (wr_arb && arb_ch == 2'(c) && reg_wdata[16:0] != 17'h00000) begin // R1 R16
        sel_p[c] = 1'b1;
        sel_seg[c] = reg_wdata[16:0];
      end else if (hit && hit_ch == 2'(c) && hit_seg != 17'h00000) begin // R18 R11
        sel_p[c] = 1'b1;
        sel_seg[c] = hit_seg;
      end
      task_rd[c] = task_mem[tix(c, tptr_reg[c])];
      start_c[c] = seg_start_mem[seg_ix(cur_seg_reg[c])];
      len_c[c] = seg_len_mem[seg_ix(cur_seg_reg[c])];
      mb_c[c] = seg_mb_mem[seg_ix(cur_seg_reg[c])];
      last_c[c] = (off_reg[c] + 32'h00000001) >= len_c[c];
    end
  end

  // Register file
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= wss_pkg::CTRL_RST;
      task_idx_reg <= '0;
      task_lo_reg <= '0;
      scen_idx_reg <= '0;
      seg_idx_reg <= '0;
      seg_start_reg <= '0;
      seg_len_reg <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        wss_pkg::OFF_CTRL: ctrl_reg <= reg_wdata[2:0];
        wss_pkg::OFF_TASK_IDX: task_idx_reg <= reg_wdata;
        wss_pkg::OFF_TASK_LO: task_lo_reg <= reg_wdata;
        wss_pkg::OFF_SCEN_IDX: scen_idx_reg <= reg_wdata;
        wss_pkg::OFF_SEG_IDX: seg_idx_reg <= reg_wdata[15:0];
        wss_pkg::OFF_SEG_START: seg_start_reg <= reg_wdata;
        wss_pkg::OFF_SEG_LEN: seg_len_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Table memories, loaded from the staging registers
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr == wss_pkg::OFF_TASK_HI) begin
      task_mem[{task_idx_reg[17:16], task_idx_reg[15:0]}] <= '{ // R2 R3
        seg: task_lo_reg[16:0],
        loops: task_lo_reg[wss_pkg::LO_LOOP_LSB +: wss_pkg::LOOP_W],
        next: reg_wdata[15:0],
        last: reg_wdata[wss_pkg::HI_END],
        cond: reg_wdata[wss_pkg::HI_COND_LSB +: 2],
        adv: reg_wdata[wss_pkg::HI_ADV_LSB +: 2]};
    end
    if (reg_wr && reg_addr == wss_pkg::OFF_SCEN_DATA) begin
      scen_mem[{scen_idx_reg[17:16], scen_idx_reg[9:0]}] <= reg_wdata[15:0]; // R4
    end
    if (reg_wr && reg_addr == wss_pkg::OFF_SEG_MBASE) begin
      seg_start_mem[seg_idx_reg] <= seg_start_reg;
      seg_len_mem[seg_idx_reg] <= seg_len_reg; // R8
      seg_mb_mem[seg_idx_reg] <= reg_wdata; // R7
    end
  end

  // Scenario length per channel; default table until software writes one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dflt_reg <= '1;
      for (int c = 0; c < NUM_CH; c++) begin
        scen_cnt_reg[c] <= wss_pkg::SCEN_DFLT_CNT; // R5
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (reg_wr && (reg_addr == wss_pkg::OFF_SCEN_DATA || reg_addr == wss_pkg::OFF_SCEN_CNT)
            && scen_idx_reg[17:16] == 2'(c)) begin
          dflt_reg[c] <= 1'b0;
        end
        if (reg_wr && reg_addr == wss_pkg::OFF_SCEN_CNT && reg_wdata[17:16] == 2'(c)) begin
          scen_cnt_reg[c] <= reg_wdata[10:0]; // R4
        end
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          wss_pkg::OFF_CTRL: reg_rdata <= {29'h00000000, ctrl_reg};
          wss_pkg::OFF_TASK_IDX: reg_rdata <= task_idx_reg;
          wss_pkg::OFF_TASK_LO: reg_rdata <= task_lo_reg;
          wss_pkg::OFF_SCEN_IDX: reg_rdata <= scen_idx_reg;
          wss_pkg::OFF_SEG_IDX: reg_rdata <= {16'h0000, seg_idx_reg};
          wss_pkg::OFF_SEG_START: reg_rdata <= seg_start_reg;
          wss_pkg::OFF_SEG_LEN: reg_rdata <= seg_len_reg;
          wss_pkg::OFF_STATUS: begin
            for (int c = 0; c < NUM_CH; c++) begin
              reg_rdata[c] <= st_reg[c] == wss_pkg::S_PLAY || st_reg[c] == wss_pkg::S_TASK;
              reg_rdata[wss_pkg::STAT_DONE_LSB + c] <= st_reg[c] == wss_pkg::S_DONE;
            end
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // One request per cycle, channels in turn at one shared rate
  assign issue = run && !stream && buf_ready && st_reg[rr_reg] == wss_pkg::S_PLAY
    && !sel_p[rr_reg] && !start_p;

  always_comb begin
    in_d.ch = rr_reg;
    in_d.addr = start_c[rr_reg] + off_reg[rr_reg]; // R14
    in_d.maddr = mb_c[rr_reg] + off_reg[rr_reg]; // R7 R8
    in_d.last = last_c[rr_reg];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rr_reg <= '0;
    end else begin
      rr_reg <= (rr_reg == 2'(NUM_CH - 1)) ? 2'h0 : rr_reg + 2'h1; // R15
    end
  end

  // Channel sequencing
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tend_reg <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        st_reg[c] <= wss_pkg::S_IDLE;
        cur_seg_reg[c] <= '0;
        arb_seg_reg[c] <= '0;
        off_reg[c] <= '0;
        loops_reg[c] <= '0;
        tptr_reg[c] <= '0;
        tnext_reg[c] <= '0;
        line_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (sel_p[c]) begin
          arb_seg_reg[c] <= sel_seg[c];
        end
        if (start_p) begin
          off_reg[c] <= '0;
          if (task_mode) begin
            st_reg[c] <= wss_pkg::S_TASK;
            line_reg[c] <= '0;
            tptr_reg[c] <= scen_ptr(c, 10'h000); // R5 R6
          end else if (sel_p[c] || arb_seg_reg[c] != 17'h00000) begin
            st_reg[c] <= wss_pkg::S_PLAY;
            cur_seg_reg[c] <= sel_p[c] ? sel_seg[c] : arb_seg_reg[c]; // R1
          end else begin
            st_reg[c] <= wss_pkg::S_IDLE;
          end
        end else if (!run) begin
          st_reg[c] <= wss_pkg::S_IDLE;
        end else if (!task_mode && sel_p[c]) begin
          st_reg[c] <= wss_pkg::S_PLAY; // R1 R18
          cur_seg_reg[c] <= sel_seg[c];
          off_reg[c] <= '0;
        end else begin
          case (st_reg[c])
            wss_pkg::S_TASK: begin
              cur_seg_reg[c] <= task_rd[c].seg; // R2
              loops_reg[c] <= task_rd[c].loops;
              tnext_reg[c] <= task_rd[c].next;
              tend_reg[c] <= task_rd[c].last;
              off_reg[c] <= '0;
              st_reg[c] <= (task_rd[c].seg == 17'h00000) ? wss_pkg::S_DONE : wss_pkg::S_PLAY;
            end
            wss_pkg::S_PLAY: begin
              if (issue && rr_reg == 2'(c)) begin
                if (!last_c[c]) begin
                  off_reg[c] <= off_reg[c] + 32'h00000001; // R14
                end else begin
                  off_reg[c] <= '0;
                  if (!task_mode) begin
                    st_reg[c] <= wss_pkg::S_PLAY;
                  end else if (loops_reg[c] > 15'h0001) begin
                    loops_reg[c] <= loops_reg[c] - 15'h0001;
                  end else if (!tend_reg[c]) begin
                    tptr_reg[c] <= tnext_reg[c]; // R6
                    st_reg[c] <= wss_pkg::S_TASK;
                  end else if (11'(line_reg[c]) + 11'h001 < scen_count(c)) begin
                    line_reg[c] <= line_reg[c] + 10'h001; // R6
                    tptr_reg[c] <= scen_ptr(c, line_reg[c] + 10'h001);
                    st_reg[c] <= wss_pkg::S_TASK;
                  end else begin
                    st_reg[c] <= wss_pkg::S_DONE;
                  end
                end
              end
            end
            wss_pkg::S_IDLE, wss_pkg::S_DONE: begin
            end
            default: st_reg[c] <= wss_pkg::S_IDLE;
          endcase
        end
      end
    end
  end

  wss_skid_buf #(
    .WIDTH($bits(wss_pkg::wss_req_t))
  ) u_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(issue),
    .in_ready(buf_ready),
    .in_data(in_d),
    .out_valid(req_valid),
    .out_ready(req_ready),
    .out_data(req_data)
  );

  // Marker enables, split evenly and dropped while streaming
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      marker_en <= '0;
      stream_active <= 1'b0;
    end else begin
      stream_active <= stream;
      for (int m = 0; m < NUM_MARK; m++) begin
        marker_en[m] <= !stream && st_reg[m / MPC] == wss_pkg::S_PLAY; // R7 R9 R12
      end
    end
  end

  // Helper for the jump check
  logic ap_valid;
  logic [wss_pkg::CH_W-1:0] ap_ch;
  logic [wss_pkg::SEGNUM_W-1:0] ap_seg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ap_valid <= 1'b0;
      ap_ch <= '0;
      ap_seg <= '0;
    end else begin
      ap_valid <= hit && hit_seg != 17'h00000 && run && !task_mode && !start_p && !wr_arb;
      ap_ch <= hit_ch;
      ap_seg <= hit_seg;
    end
  end

  chk_jump_apply: assert property (@(posedge clk_sys) disable iff (sys_rst) // R18
    ap_valid |-> cur_seg_reg[ap_ch] == ap_seg && off_reg[ap_ch] == 32'h00000000)
    else $error("jump not applied to named channel");

  chk_stream_marks: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
    stream |=> marker_en == '0 && stream_active)
    else $error("markers active while streaming");

  chk_stream_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
    stream |-> !issue)
    else $error("memory read during streaming");

  chk_addr_order: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
    issue |-> in_d.addr == start_c[rr_reg] + off_reg[rr_reg] && off_reg[rr_reg] < len_c[rr_reg]
      || len_c[rr_reg] == 32'h00000000)
    else $error("sample address out of sequence");

  chk_marker_len: assert property (@(posedge clk_sys) disable iff (sys_rst) // R8
    issue |-> in_d.maddr - mb_c[rr_reg] == in_d.addr - start_c[rr_reg])
    else $error("marker offset differs from sample offset");

  chk_seg_range: assert property (@(posedge clk_sys) disable iff (sys_rst) // R16
    issue |-> cur_seg_reg[rr_reg] != 17'h00000)
    else $error("segment number zero played");

  chk_one_owner: assert property (@(posedge clk_sys) disable iff (sys_rst) // R15
    issue |-> in_d.ch == rr_reg ##1 rr_reg != $past(rr_reg) || NUM_CH == 1)
    else $error("request not tied to turn owner");

  chk_default_scen: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    dflt_reg[0] |-> scen_count(0) == 11'h001 && scen_ptr(0, 10'h000) == 16'h0000)
    else $error("default scenario wrong");

endmodule

// ---- wss_sequencer_tb.sv ----
// Self-checking bench of the waveform segment sequencer.
// Assumes the memory model and the package are compiled first.
`timescale 1ns/1ps
module wss_sequencer_tb;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, jump_valid = 0, slow = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [1:0] jump_sel = 2'h0;
  logic [9:0] jump_idx = 10'h000;
  logic req_valid, req_ready, stream_active;
  logic [7:0] marker_en;
  wss_pkg::wss_req_t req_data;
  wss_pkg::wss_req_t q[$];
  int num_errors = 0, cmp_count = 0, cyc = 0;
  wss_sequencer dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .jump_valid(jump_valid), .jump_sel(jump_sel), .jump_idx(jump_idx),
    .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
    .stream_active(stream_active), .marker_en(marker_en));
  wss_mem_model mem_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .req_ready(req_ready));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (req_valid && req_ready && req_data.ch == 2'h0) q.push_back(req_data);
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic t_reset();
    rd(wss_pkg::OFF_STATUS);
    chk("status", 32'h0, d);
    rd(8'hFC);
    chk("unmapped", 32'h0, d);
    chk("req_valid", 32'h0, {31'h0, req_valid});
  endtask
  task automatic t_arb();
    wr(wss_pkg::OFF_SEG_IDX, 32'h0);
    wr(wss_pkg::OFF_SEG_START, 32'h100);
    wr(wss_pkg::OFF_SEG_LEN, 32'h2);
    wr(wss_pkg::OFF_SEG_MBASE, 32'h800);
    wr(wss_pkg::OFF_ARB_SEL, 32'h1);
    wr(wss_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 200 && q.size() < 3; i++) @(posedge clk_sys);
    chk("addr0", 32'h100, q[0].addr);
    chk("addr1", 32'h101, q[1].addr);
    chk("last1", 32'h1, {31'h0, q[1].last});
    chk("addr2", 32'h100, q[2].addr);
    chk("maddr1", 32'h801, q[1].maddr);
    chk("marker", 32'h03, {24'h0, marker_en});
  endtask
  task automatic t_jump();
    jump_sel <= 2'h2;
    repeat (3) @(posedge clk_sys);
    chk("marker", 32'h03, {24'h0, marker_en});
    jump_sel <= 2'h1;
    jump_valid <= 1'b1;
    @(posedge clk_sys);
    jump_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("marker", 32'h0F, {24'h0, marker_en});
  endtask
  task automatic t_stream();
    wr(wss_pkg::OFF_CTRL, 32'h5);
    repeat (3) @(posedge clk_sys);
    chk("stream", 32'h1, {31'h0, stream_active});
    chk("marker", 32'h0, {24'h0, marker_en});
  endtask
  task automatic t_task();
    wr(wss_pkg::OFF_CTRL, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(wss_pkg::OFF_TASK_IDX, {14'h0, c[1:0], 16'h0});
      wr(wss_pkg::OFF_TASK_LO, (c == 0) ? 32'h1 : 32'h0);
      wr(wss_pkg::OFF_TASK_HI, 32'h10000);
    end
    repeat (4) @(posedge clk_sys);
    q.delete();
    wr(wss_pkg::OFF_CTRL, 32'h3);
    d = 32'h0;
    for (int i = 0; i < 100 && d !== 32'hF0; i++) rd(wss_pkg::OFF_STATUS);
    chk("status", 32'hF0, d);
    repeat (4) @(posedge clk_sys);
    chk("count", 32'h2, q.size());
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_arb();
    t_jump();
    t_stream();
    t_task();
    end_of_test();
  end
endmodule

// ---- wss_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may hold ready low for any time.
`timescale 1ns/1ps
module wss_skid_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] spare_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 2'h0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
      out_data <= '0;
      spare_reg <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          cnt_reg <= cnt_reg + 2'h1;
          out_valid <= 1'b1;
          in_ready <= (cnt_reg == 2'h0);
          if (cnt_reg == 2'h0) begin
            out_data <= in_data;
          end else begin
            spare_reg <= in_data;
          end
        end
        2'b01: begin
          cnt_reg <= cnt_reg - 2'h1;
          out_valid <= (cnt_reg == 2'h2);
          in_ready <= 1'b1;
          out_data <= spare_reg;
        end
        2'b11: begin
          if (cnt_reg == 2'h1) begin
            out_data <= in_data;
          end else begin
            out_data <= spare_reg;
            spare_reg <= in_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  chk_buf_full: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
    cnt_reg == 2'h2 |-> !in_ready && out_valid)
    else $error("buffer full but accepting");

  chk_buf_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word changed or lost");

endmodule
